// ---- psc_defines.svh ----
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ==========================================================
// Frame layout
`define PSC_FRAME_BITS     4'h8
`define PSC_FRAME_WR_BIT   7
`define PSC_FRAME_ADDR_HI  6
`define PSC_FRAME_ADDR_LO  5

// ==========================================================
// Register addresses
`define PSC_ADDR_LOAD      2'h0
`define PSC_ADDR_GUARD     2'h1
`define PSC_ADDR_SETUP     2'h2

// ==========================================================
// Field positions
`define PSC_SETUP_CLEAR_BIT    0
`define PSC_SETUP_COMBINE_BIT  1

// ==========================================================
// Reset values
`define PSC_LOAD_RESET     5'h00
`define PSC_LAMP_RESET     3'h0
`define PSC_COMBINE_RESET  1'h0

`endif

// ---- psc_pkg.sv ----
package psc_pkg;

   // ==========================================================
   // Serial frame as seen by the register bank
   typedef struct packed {
      logic       wr;
      logic [1:0] addr;
      logic [4:0] data;
   } psc_frame_t;

   // Channel vectors that travel together
   typedef struct packed {
      logic [4:0] drive;
      logic [2:0] lamp;
      logic       combine_and;
   } psc_ctrl_t;

endpackage : psc_pkg

// ---- psc_spi_slave.sv ----
`timescale 1ns/10ps
`include "psc_defines.svh"

module psc_spi_slave
(
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                sclk_in,
   input  wire logic                cs_n_in,
   input  wire logic                mosi_in,
   input  wire psc_pkg::psc_frame_t tx_in,
   output      logic                miso_out,
   output      logic                miso_oe_n_out,
   output      psc_pkg::psc_frame_t rx_out,
   output      logic                rx_valid_out
);

   logic [2:0] sclk_q;
   logic [2:0] cs_q;
   logic [1:0] mosi_q;
   logic [7:0] rx_sr_q;
   logic [7:0] tx_sr_q;
   logic [3:0] bit_cnt_q;
   logic       rise;
   logic       fall;
   logic       cs_start;
   logic       cs_end;

   // ==========================================================
   // Input synchronisers
   // Two stages, third only for edge finding
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sclk_q <= 3'h0;
         cs_q   <= 3'h7;
         mosi_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk_in};
         cs_q   <= {cs_q[1:0], cs_n_in};
         mosi_q <= {mosi_q[0], mosi_in};
      end
   end

   // Edges from stages two and three
   assign rise     = sclk_q[1] & ~sclk_q[2];
   assign fall     = ~sclk_q[1] & sclk_q[2];
   assign cs_start = ~cs_q[1] & cs_q[2];
   assign cs_end   = cs_q[1] & ~cs_q[2];

   // ==========================================================
   // Receive shifter, sampled on rising clock
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_sr_q   <= 8'h00;
         bit_cnt_q <= 4'h0;
      end
      else if (cs_start)
      begin
         bit_cnt_q <= 4'h0;
      end
      else if (rise && !cs_q[1])
      begin
         rx_sr_q <= {rx_sr_q[6:0], mosi_q[1]};
         if (bit_cnt_q != 4'hf)
         begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
   end

   // Frame hand-over, only whole frames count
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_out       <= '0;
         rx_valid_out <= 1'h0;
      end
      else
      begin
         rx_valid_out <= cs_end && (bit_cnt_q == `PSC_FRAME_BITS);
         if (cs_end && (bit_cnt_q == `PSC_FRAME_BITS))
         begin
            rx_out <= rx_sr_q;
         end
      end
   end

   // ==========================================================
   // Transmit shifter, changes on falling clock
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tx_sr_q       <= 8'h00;
         miso_out      <= 1'h0;
         miso_oe_n_out <= 1'h1;
      end
      else if (cs_start)
      begin
         tx_sr_q       <= {tx_in[6:0], 1'h0};
         miso_out      <= tx_in[7];
         miso_oe_n_out <= 1'h0;
      end
      else if (cs_end)
      begin
         miso_oe_n_out <= 1'h1;
      end
      else if (fall && !cs_q[1])
      begin
         miso_out <= tx_sr_q[7];
         tx_sr_q  <= {tx_sr_q[6:0], 1'h0};
      end
   end

endmodule : psc_spi_slave

// ---- psc_channel_ctrl.sv ----
`timescale 1ns/10ps
`include "psc_defines.svh"

// ==========================================================
// Summary of operation
// [R1] Five drive bits request channels on
// [R2] Three lamp bits pick bulb or LED
// [R3] Setup bit one picks OR or AND
// [R4] Overheat latches channel off, survives logic reset
// [R5] Host writes one to clear latches
// [R6] Setup bit zero clears all; zero ignored
// [R7] Gate on: request active, latch clear
module psc_channel_ctrl
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       thermal_rst_n_in,
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic       mosi_in,
   input  wire logic [4:0] chan_pin_in,
   input  wire logic [4:0] over_temp_in,
   output logic            miso_out,
   output logic            miso_oe_n_out,
   output logic [4:0]      gate_on_out,
   output logic [2:0]      lamp_led_out,
   output logic [4:0]      thermal_latch_out
);

   psc_pkg::psc_frame_t rx;
   logic                rx_valid;
   psc_pkg::psc_frame_t tx_q;
   psc_pkg::psc_ctrl_t  ctrl;
   logic [4:0]          drive_q;
   logic [2:0]          lamp_q;
   logic                combine_q;
   logic [4:0]          pin_s1_q;
   logic [4:0]          pin_s2_q;
   logic [4:0]          ot_s1_q;
   logic [4:0]          ot_s2_q;
   logic [4:0]          latch_q;
   logic [4:0]          latch_d;
   logic [4:0]          request;
   logic                wr_load;
   logic                wr_guard;
   logic                wr_setup;
   logic                clear_cmd;

   // ==========================================================
   // Read value of one register
   function automatic logic [4:0] read_reg
   (
      input logic [1:0]         addr,
      input psc_pkg::psc_ctrl_t c
   );
      logic [4:0] v;
      v = 5'h00;
      case (addr)
         `PSC_ADDR_LOAD:  v = c.drive;
         `PSC_ADDR_GUARD: v = {2'h0, c.lamp};
         `PSC_ADDR_SETUP: v = {3'h0, c.combine_and, 1'h0};
         default:         v = 5'h00;
      endcase
      return v;
   endfunction : read_reg

   // ==========================================================
   // Serial port engine
   psc_spi_slave psc_spi_slave_inst
   (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .sclk_in       (sclk_in),
      .cs_n_in       (cs_n_in),
      .mosi_in       (mosi_in),
      .tx_in         (tx_q),
      .miso_out      (miso_out),
      .miso_oe_n_out (miso_oe_n_out),
      .rx_out        (rx),
      .rx_valid_out  (rx_valid)
   );

   // ==========================================================
   // Pin and sensor synchronisers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         ot_s1_q  <= 5'h00;
         ot_s2_q  <= 5'h00;
      end
      else
      begin
         pin_s1_q <= chan_pin_in;
         pin_s2_q <= pin_s1_q;
         ot_s1_q  <= over_temp_in;
         ot_s2_q  <= ot_s1_q;
      end
   end

   // ==========================================================
   // Write decode
   assign wr_load   = rx_valid && rx.wr && (rx.addr == `PSC_ADDR_LOAD);
   assign wr_guard  = rx_valid && rx.wr && (rx.addr == `PSC_ADDR_GUARD);
   assign wr_setup  = rx_valid && rx.wr && (rx.addr == `PSC_ADDR_SETUP);
   // One-shot clear, a zero write does nothing
   assign clear_cmd = wr_setup && rx.data[`PSC_SETUP_CLEAR_BIT]; // [R5] [R6]

   // Channel drive bits, one per channel
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         drive_q <= `PSC_LOAD_RESET;
      end
      else if (wr_load)
      begin
         drive_q <= rx.data; // [R1]
      end
   end

   // Lamp type bits; upper write bits ignored
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         lamp_q <= `PSC_LAMP_RESET;
      end
      else if (wr_guard)
      begin
         lamp_q <= rx.data[2:0]; // [R2]
      end
   end

   // Input combine mode
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         combine_q <= `PSC_COMBINE_RESET;
      end
      else if (wr_setup)
      begin
         combine_q <= rx.data[`PSC_SETUP_COMBINE_BIT]; // [R3]
      end
   end

   // Control fields gathered as one carrier
   // One writer per field, single driver each
   assign ctrl = '{drive: drive_q, lamp: lamp_q, combine_and: combine_q};

   // ==========================================================
   // Read answer for the next frame
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tx_q <= '0;
      end
      else if (rx_valid)
      begin
         tx_q.wr   <= 1'h0;
         tx_q.addr <= rx.addr;
         tx_q.data <= read_reg(rx.addr, ctrl);
      end
      else
      begin
         tx_q.data <= read_reg(tx_q.addr, ctrl);
      end
   end

   // ==========================================================
   // Thermal latches
   // Set wins over a clear in the same cycle
   assign latch_d = (latch_q & ~{5{clear_cmd}}) | ot_s2_q; // [R4] [R5]

   // Own reset so a logic reset keeps the latch
   always_ff @(posedge clk_in or negedge thermal_rst_n_in)
   begin
      if (!thermal_rst_n_in)
      begin
         latch_q <= 5'h00;
      end
      else
      begin
         latch_q <= latch_d; // [R4]
      end
   end

   // ==========================================================
   // Request combine and gate drive
   assign request = ctrl.combine_and ? (pin_s2_q & ctrl.drive)
                                     : (pin_s2_q | ctrl.drive); // [R3]

   // Gate off at once when a latch sets
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         gate_on_out <= 5'h00;
      end
      else
      begin
         gate_on_out <= request & ~latch_d; // [R7] [R4]
      end
   end

   // Status outputs
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         lamp_led_out      <= `PSC_LAMP_RESET;
         thermal_latch_out <= 5'h00;
      end
      else
      begin
         lamp_led_out      <= ctrl.lamp; // [R2]
         thermal_latch_out <= latch_q;
      end
   end

endmodule : psc_channel_ctrl

// ---- psc_chk.sv ----
`timescale 1ns/10ps
// ==========================================================
// Port checker
module psc_chk
(
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       thermal_rst_n_in,
   input wire logic       cs_n_in,
   input wire logic [4:0] chan_pin_in,
   input wire logic [4:0] over_temp_in,
   input wire logic       miso_oe_n_out,
   input wire logic [4:0] gate_on_out,
   input wire logic [2:0] lamp_led_out,
   input wire logic [4:0] thermal_latch_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in || !thermal_rst_n_in);

   // Gate and latch, heat and serial quiet
   a_gate_latch_excl: assert property (1 |=>
      (thermal_latch_out & $past(gate_on_out)) == 5'h00) else $error("gate on while latched");
   a_all_hot: assert property (over_temp_in == 5'h1f [*8] |->
      thermal_latch_out == 5'h1f && gate_on_out == 5'h00) else $error("hot not latched");
   a_hot_one: assert property (over_temp_in[3] [*8] |->
      !gate_on_out[3] && thermal_latch_out[3]) else $error("channel 3 not latched");
   a_latch_holds: assert property (cs_n_in [*8] |=>
      (~thermal_latch_out & $past(thermal_latch_out)) == 5'h00) else $error("latch dropped");
   a_lamp_stable: assert property (cs_n_in [*8] |=> $stable(lamp_led_out))
      else $error("lamp moved without frame");
   a_gate_stable: assert property ((cs_n_in && over_temp_in == 5'h00
      && $stable(chan_pin_in)) [*8] |=> $stable(gate_on_out)) else $error("gate moved");
   a_oe_idle: assert property (cs_n_in [*4] |-> miso_oe_n_out)
      else $error("miso driven while idle");
   a_oe_drive: assert property (!cs_n_in [*4] |-> !miso_oe_n_out)
      else $error("miso not driven in frame");
   c_hot: cover property (over_temp_in == 5'h1f [*8]);
   c_clear: cover property (thermal_latch_out != 5'h00 ##1 thermal_latch_out == 5'h00);
   c_frame: cover property (!miso_oe_n_out ##1 miso_oe_n_out);
endmodule : psc_chk

bind psc_channel_ctrl psc_chk psc_chk_inst (.*);

// ---- psc_host_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Host serial master, mode 0
module psc_host_model
(
   input  wire logic clk_in,
   input  wire logic miso_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out
);
   // Idle lines
   initial
   begin
      sclk_out = 1'h0;
      cs_n_out = 1'h1;
      mosi_out = 1'h0;
   end

   // One frame, MSB first, 800 ns bit period
   task automatic xfer(input logic [7:0] w, output logic [7:0] r);
      @(negedge clk_in) cs_n_out = 1'h0;
      for (int i = 7; i >= 0; i--)
      begin
         mosi_out = w[i];
         repeat (4) @(negedge clk_in);
         r[i] = miso_in;
         sclk_out = 1'h1;
         repeat (4) @(negedge clk_in);
         sclk_out = 1'h0;
      end
      repeat (4) @(negedge clk_in);
      cs_n_out = 1'h1;
      mosi_out = ~mosi_out; // Released line toggles
      repeat (10) @(negedge clk_in);
   endtask : xfer

   // Register write and read
   task automatic wr(input logic [1:0] a, input logic [4:0] d);
      logic [7:0] r;
      xfer({1'b1, a, d}, r);
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [4:0] d);
      logic [7:0] r;
      xfer({1'b0, a, 5'h00}, r);
      xfer(8'h00, r);
      d = r[4:0];
   endtask : rd
endmodule : psc_host_model

// ---- testbench.sv ----
`timescale 1ns/10ps
// ==========================================================
// Bench top
module testbench;
   logic       clk_in;
   logic       rst_n_in;
   logic       trst_n;
   logic       sclk, cs_n, mosi, miso, oe_n;
   logic [4:0] pins, hot, gate, latch, rdv;
   logic [2:0] lamp;
   int         errors;
   int         compares;

   // Clock, 100 ns
   initial
   begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end

   psc_channel_ctrl psc_channel_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .thermal_rst_n_in(trst_n), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
      .chan_pin_in(pins), .over_temp_in(hot), .miso_out(miso), .miso_oe_n_out(oe_n),
      .gate_on_out(gate), .lamp_led_out(lamp), .thermal_latch_out(latch));

   // Released miso shows inverted level
   psc_host_model psc_host_model_inst (.clk_in(clk_in), .miso_in(miso ^ oe_n),
      .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

   task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wrap_up;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // Reset values, drive bits, read back
   task automatic t_drive;
      chk("lamp rst", 5'h00, {2'h0, lamp});
      psc_host_model_inst.rd(2'h0, rdv);
      chk("load rst", 5'h00, rdv);
      psc_host_model_inst.wr(2'h0, 5'h0a);
      chk("gate on", 5'h0a, gate);
      psc_host_model_inst.rd(2'h0, rdv);
      chk("load rd", 5'h0a, rdv);
   endtask : t_drive

   // Lamp bits, dead bits, unmapped place
   task automatic t_lamp;
      psc_host_model_inst.wr(2'h1, 5'h1f);
      chk("lamp set", 5'h07, {2'h0, lamp});
      psc_host_model_inst.rd(2'h1, rdv);
      chk("lamp rd", 5'h07, rdv);
      psc_host_model_inst.wr(2'h3, 5'h1f);
      psc_host_model_inst.rd(2'h3, rdv);
      chk("unmapped", 5'h00, rdv);
   endtask : t_lamp

   // OR then AND with pins
   task automatic t_combine;
      pins = 5'h0c;
      repeat (6) @(negedge clk_in);
      chk("or mix", 5'h0e, gate);
      psc_host_model_inst.wr(2'h2, 5'h02);
      chk("and mix", 5'h08, gate);
      psc_host_model_inst.rd(2'h2, rdv);
      chk("setup rd", 5'h02, rdv);
   endtask : t_combine

   // Latch, logic reset, clear
   task automatic t_thermal;
      hot = 5'h08;
      repeat (10) @(negedge clk_in);
      hot = 5'h00;
      repeat (10) @(negedge clk_in);
      chk("latch one", 5'h08, latch);
      chk("gate off", 5'h00, gate);
      psc_host_model_inst.wr(2'h2, 5'h02);
      chk("no clear", 5'h08, latch);
      rst_n_in = 1'h0;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'h1;
      repeat (6) @(negedge clk_in);
      chk("kept", 5'h08, latch);
      chk("gate rst", 5'h04, gate);
      hot = 5'h1f;
      repeat (10) @(negedge clk_in);
      chk("all hot", 5'h00, gate);
      psc_host_model_inst.wr(2'h2, 5'h01);
      chk("set wins", 5'h1f, latch);
      hot = 5'h00;
      psc_host_model_inst.wr(2'h2, 5'h01);
      chk("cleared", 5'h00, latch);
      chk("gate back", 5'h0c, gate);
   endtask : t_thermal

   // Main sequence
   initial
   begin
      errors = 0;
      compares = 0;
      rst_n_in = 1'h0;
      trst_n = 1'h0;
      pins = 5'h00;
      hot = 5'h00;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'h1;
      trst_n = 1'h1;
      repeat (4) @(negedge clk_in);
      t_drive;
      t_lamp;
      t_combine;
      t_thermal;
      wrap_up;
   end

   // Watchdog
   initial
   begin
      #1000000;
      errors++;
      wrap_up;
   end
endmodule : testbench
